/* rtl/dod_half_tick.sv */
// half-step tick source for the distribution path
// assumes clk edges stand for oscillator half-periods
`timescale 1ns/100ps
module dod_half_tick #(
    parameter int PDIV_W = 4
) (
    input wire logic clk, // block clock
    input wire logic rst_n, // synchronised reset, active low
    input wire logic ce, // clock enable, freezes state when low
    input wire logic bypass, // post-divider bypassed
    input wire logic [PDIV_W-1:0] post_div, // oscillator_post_divide
    output logic tick // one half step of the distribution clock
);
    logic [PDIV_W-1:0] cnt_q;
    logic [PDIV_W-1:0] cnt_d;
    logic wrap;

    // a divide of 0 or 1 behaves as bypass, so the tick never stops
    assign wrap = bypass || (post_div <= PDIV_W'(1)) || (cnt_q >= post_div - PDIV_W'(1));
    assign cnt_d = wrap ? '0 : cnt_q + PDIV_W'(1);
    assign tick = ce && wrap;

    // ----------------------------------------
    // post-divider count
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (ce) begin
            cnt_q <= cnt_d;
        end
    end
endmodule

/* rtl/dod_pair_div.sv */
// one output pair's divider with a restartable hold-off
// assumes tick marks one half step of the distribution clock
`timescale 1ns/100ps
module dod_pair_div #(
    parameter int DIV_W = 11,
    parameter int HOLD_W = 7
) (
    input wire logic clk, // block clock
    input wire logic rst_n, // synchronised reset, active low
    input wire logic ce, // clock enable
    input wire logic tick, // half-step tick
    input wire logic [DIV_W-1:0] divide, // pair_output_divide
    input wire logic restart, // pulse: hold off, then restart in phase
    input wire logic [HOLD_W-1:0] hold_len, // hold-off in half steps
    output logic clk_out, // divided output, registered
    output logic rise // pulse: output about to rise
);
    logic [DIV_W:0] ph_q;
    logic [DIV_W:0] ph_d;
    logic [DIV_W:0] half_len;
    logic [DIV_W:0] per_len;
    logic hold_q;
    logic [HOLD_W-1:0] hcnt_q;
    logic at_end;
    logic hold_done;

    // divide of 0 treated as 1 so the output keeps toggling
    assign half_len = (divide == '0) ? (DIV_W+1)'(1) : {1'b0, divide};
    assign per_len = half_len << 1;
    assign at_end = ph_q >= per_len - (DIV_W+1)'(1);
    assign ph_d = at_end ? '0 : ph_q + (DIV_W+1)'(1);
    assign hold_done = hcnt_q <= HOLD_W'(1);
    assign rise = tick && !hold_q && at_end;

    // ----------------------------------------
    // phase and hold-off
    // ----------------------------------------
    // other pairs never see restart, so they run on untouched
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_q <= '0;
            hold_q <= 1'b0;
            hcnt_q <= '0;
            clk_out <= 1'b0;
        end else if (ce) begin
            if (restart) begin
                hold_q <= 1'b1;
                hcnt_q <= hold_len;
                clk_out <= 1'b0;
            end else if (tick && hold_q) begin
                if (hold_done) begin
                    hold_q <= 1'b0;
                    ph_q <= '0;
                    clk_out <= 1'b1;
                end else begin
                    hcnt_q <= hcnt_q - HOLD_W'(1);
                end
            end else if (tick) begin
                ph_q <= ph_d;
                clk_out <= ph_d < half_len;
            end
        end
    end
endmodule

/* rtl/dod_top.sv */
// dynamic output delay: realigns output pairs to a qualifying pair on sync
// assumes a plain register port and a synchronous sync request pin
//
// Operation
// - delay moves in distribution half-period steps
// - delay equals count minus half when flagged
// - feedback-selected pair is the qualifying clock
// - self-qualified pair shifts again each sync
// - new delay applied with minimal output interruption
// - zero-offset value independent of synced divide
// - larger delay holds output off longer
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "dod_cfg.svh"
module dod_top #(
    parameter int NPAIRS = 7,
    parameter int PDIV_W = 4,
    parameter int CNT_W = 8
) (
    input wire logic clk, // block clock, oscillator half-period ticks
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic ce, // clock enable, freezes all state but the reset release flops when low
    input wire logic sync_req, // synchronisation event pin, one cycle high
    input wire logic [7:0] addr, // register byte address
    input wire logic [31:0] wdata, // register write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [31:0] rdata, // read data, valid the cycle after rd
    output logic [NPAIRS-1:0] clk_out, // one output per pair
    output logic busy // sync accepted, waiting for qualifying edge
);
    import dod_pkg::*;

    localparam int HOLD_W = DOD_DLY_W + 1;

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_s1_q;
    logic rst_s2_q;
    logic rst_l_n;

    // async assert, release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_l_n = rst_s2_q;

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    logic [31:0] ctrl_q;
    logic [NPAIRS-1:0] sync_en_q;
    logic [CNT_W-1:0] sync_cnt_q;
    logic [31:0] rdata_d;
    logic wr_ctrl;
    logic wr_sync_en;
    logic wr_sync_cmd;
    logic sel_ctrl;
    logic sel_sync_en;
    logic sel_status;
    logic sel_pair;
    logic [5:0] pair_idx;
    logic pair_hit;
    logic bypass;
    logic [PDIV_W-1:0] post_div;
    logic [2:0] qual_sel;
    dod_pair_cfg_t pair_cfg_q [NPAIRS];
    logic [31:0] pair_rd [NPAIRS];

    assign sel_ctrl = (addr == `DOD_CTRL_OFS);
    assign sel_sync_en = (addr == `DOD_SYNC_EN_OFS);
    assign sel_status = (addr == `DOD_STATUS_OFS);
    assign pair_idx = 6'((addr - `DOD_PAIR_BASE_OFS) >> 2);
    assign pair_hit = (addr >= `DOD_PAIR_BASE_OFS) && (addr[1:0] == 2'h0)
        && (pair_idx < 6'(NPAIRS));
    assign sel_pair = pair_hit && !sel_ctrl;
    assign wr_ctrl = wr && sel_ctrl;
    assign wr_sync_en = wr && sel_sync_en;
    assign wr_sync_cmd = wr && (addr == `DOD_SYNC_CMD_OFS) && wdata[0];
    assign bypass = ctrl_q[`DOD_CTRL_BYPASS_BIT];
    assign post_div = ctrl_q[`DOD_CTRL_PDIV_MSB:`DOD_CTRL_PDIV_LSB];
    assign qual_sel = ctrl_q[`DOD_CTRL_QSEL_MSB:`DOD_CTRL_QSEL_LSB];

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (sel_ctrl) begin
            rdata_d = ctrl_q;
        end else if (sel_sync_en) begin
            rdata_d = 32'(sync_en_q);
        end else if (sel_status) begin
            rdata_d[`DOD_STAT_BUSY_BIT] = busy;
            rdata_d[`DOD_STAT_CNT_MSB:`DOD_STAT_CNT_LSB] = 8'(sync_cnt_q);
        end else if (sel_pair) begin
            rdata_d = pair_rd[pair_idx[$clog2(NPAIRS)-1:0]];
        end
    end

    // control registers and read data
    always_ff @(posedge clk or negedge rst_l_n) begin
        if (!rst_l_n) begin
            ctrl_q <= `DOD_CTRL_RST;
            sync_en_q <= NPAIRS'(`DOD_SYNC_EN_RST);
            rdata <= 32'h0000_0000;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl_q <= wdata & 32'h0000_07F1;
            end
            if (wr_sync_en) begin
                sync_en_q <= wdata[NPAIRS-1:0];
            end
            rdata <= rd ? rdata_d : 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // half-step tick
    // ----------------------------------------
    logic tick;

    dod_half_tick #(.PDIV_W(PDIV_W)) u_tick (
        .clk(clk),
        .rst_n(rst_l_n),
        .ce(ce),
        .bypass(bypass),
        .post_div(post_div),
        .tick(tick)
    );

    // ----------------------------------------
    // sync sequencer
    // ----------------------------------------
    dod_state_t state_q;
    logic sync_evt;
    logic qual_rise;
    logic launch;
    logic [NPAIRS-1:0] rise;
    logic [NPAIRS-1:0] act_en_q;
    logic [2:0] act_qual_q;

    assign sync_evt = sync_req || wr_sync_cmd;
    // qualifying edge picked by the feedback selection
    assign qual_rise = (act_qual_q < 3'(NPAIRS)) ? rise[act_qual_q] : 1'b0;
    assign launch = (state_q == DOD_WAIT_QUAL) && qual_rise;
    assign busy = (state_q == DOD_WAIT_QUAL);

    // a second event while waiting relatches and keeps waiting
    always_ff @(posedge clk or negedge rst_l_n) begin
        if (!rst_l_n) begin
            state_q <= DOD_IDLE;
            act_en_q <= '0;
            act_qual_q <= 3'h0;
            sync_cnt_q <= '0;
        end else if (ce) begin
            case (state_q)
                DOD_IDLE: begin
                    if (sync_evt) begin
                        state_q <= DOD_WAIT_QUAL;
                        act_en_q <= sync_en_q;
                        act_qual_q <= qual_sel;
                    end
                end
                DOD_WAIT_QUAL: begin
                    if (sync_evt) begin
                        act_en_q <= sync_en_q;
                        act_qual_q <= qual_sel;
                    end else if (launch) begin
                        state_q <= DOD_IDLE;
                        sync_cnt_q <= sync_cnt_q + CNT_W'(1);
                    end
                end
                default: begin
                    state_q <= DOD_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // per-pair registers, latch and divider
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NPAIRS; gi++) begin : g_pair
            logic wr_pair;
            logic [DOD_DLY_W-1:0] lat_cnt_q;
            logic lat_hs_q;
            logic [HOLD_W-1:0] hold_len;

            assign wr_pair = wr && sel_pair && (pair_idx == 6'(gi));
            assign pair_rd[gi] = {7'h00, pair_cfg_q[gi].half_step,
                2'h0, pair_cfg_q[gi].delay_count,
                5'h00, pair_cfg_q[gi].divide};
            // half steps: twice the count, less one when flagged
            assign hold_len = HOLD_W'({lat_cnt_q, 1'b0}) - HOLD_W'(lat_hs_q);

            // software copy; delay and half-step writes take no effect until the next sync, divide writes at once
            always_ff @(posedge clk or negedge rst_l_n) begin
                if (!rst_l_n) begin
                    pair_cfg_q[gi] <= {`DOD_PAIR_DIV_RST, `DOD_PAIR_DLY_RST,
                        `DOD_PAIR_HS_RST};
                    lat_cnt_q <= '0;
                    lat_hs_q <= 1'b0;
                end else if (ce) begin
                    if (wr_pair) begin
                        pair_cfg_q[gi].divide <=
                            wdata[`DOD_PAIR_DIV_MSB:`DOD_PAIR_DIV_LSB];
                        pair_cfg_q[gi].delay_count <=
                            wdata[`DOD_PAIR_DLY_MSB:`DOD_PAIR_DLY_LSB];
                        pair_cfg_q[gi].half_step <= wdata[`DOD_PAIR_HS_BIT];
                    end
                    if (sync_evt) begin
                        lat_cnt_q <= pair_cfg_q[gi].delay_count;
                        lat_hs_q <= pair_cfg_q[gi].half_step;
                    end
                end
            end

            // hold-off counts from the qualifying edge only, never from
            // the pair's own divide, so one value fits every pair
            dod_pair_div #(.DIV_W(DOD_DIV_W), .HOLD_W(HOLD_W)) u_div (
                .clk(clk),
                .rst_n(rst_l_n),
                .ce(ce),
                .tick(tick),
                .divide(pair_cfg_q[gi].divide),
                .restart(launch && act_en_q[gi]),
                .hold_len(hold_len),
                .clk_out(clk_out[gi]),
                .rise(rise[gi])
            );
        end
    endgenerate
endmodule

/* shared/dod_cfg.svh */
// constants of the dynamic output delay block: offsets, fields, resets
// assumes an 8-bit byte address on the register port, 32-bit data
`ifndef DOD_CFG_SVH
`define DOD_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DOD_CTRL_OFS 8'h00
`define DOD_SYNC_EN_OFS 8'h04
`define DOD_STATUS_OFS 8'h08
`define DOD_SYNC_CMD_OFS 8'h0C
`define DOD_PAIR_BASE_OFS 8'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define DOD_CTRL_BYPASS_BIT 0
`define DOD_CTRL_PDIV_LSB 4
`define DOD_CTRL_PDIV_MSB 7
`define DOD_CTRL_QSEL_LSB 8
`define DOD_CTRL_QSEL_MSB 10
`define DOD_PAIR_DIV_LSB 0
`define DOD_PAIR_DIV_MSB 10
`define DOD_PAIR_DLY_LSB 16
`define DOD_PAIR_DLY_MSB 21
`define DOD_PAIR_HS_BIT 24
`define DOD_STAT_BUSY_BIT 0
`define DOD_STAT_CNT_LSB 8
`define DOD_STAT_CNT_MSB 15

// ----------------------------------------
// reset values
// ----------------------------------------
`define DOD_CTRL_RST 32'h0000_0001
`define DOD_SYNC_EN_RST 32'h0000_0000
`define DOD_PAIR_DIV_RST 11'h00A
`define DOD_PAIR_DLY_RST 6'h0E
`define DOD_PAIR_HS_RST 1'h1

`endif

/* shared/dod_pkg.sv */
// types of the dynamic output delay block
// assumes dod_cfg.svh sits beside it on the include path
package dod_pkg;
    localparam int DOD_DIV_W = 11;
    localparam int DOD_DLY_W = 6;

    // one output pair's settings as software holds them
    typedef struct packed {
        logic [DOD_DIV_W-1:0] divide;
        logic [DOD_DLY_W-1:0] delay_count;
        logic half_step;
    } dod_pair_cfg_t;

    // sync sequencer states
    typedef enum logic [0:0] {
        DOD_IDLE,
        DOD_WAIT_QUAL
    } dod_state_t;
endpackage

/* test/dod_top_bench.sv */
// self-checking bench of the dynamic output delay top
// assumes the checker is bound in and dod_cfg.svh on the include path
`timescale 1ns/100ps
`include "dod_cfg.svh"
module dod_top_bench;
    import dod_pkg::*;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } dod_row_t;
    logic clk, rst_n, ce, sync_req, wr, rd, busy;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, rv;
    logic [6:0] clk_out;
    int error_cnt, checked, n;
    dod_row_t rows [6];
    // first row is the zero-offset value for divide 10, none below 4.5
    logic [5:0] cnt [5] = '{6'd14, 6'd14, 6'd5, 6'd15, 6'd9};
    logic hs [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    dod_top i_dod_top (.clk(clk), .rst_n(rst_n), .ce(ce), .sync_req(sync_req), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .clk_out(clk_out), .busy(busy));
    // ----------------------------------------
    // clock and tasks
    // ----------------------------------------
    always #25 clk = ~clk;
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    task conclude;
        if (error_cnt == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // bounded wait for an output level, sampled clear of the edge
    task wait_out(input int p, input logic v, output int c);
        c = 0;
        while (clk_out[p] !== v && c < 300) begin
            @(posedge clk);
            #1 c++;
        end
        // a stuck output must not leave the run hanging
        if (c == 300) begin
            chk("level", 32'h0, 32'h1);
            conclude();
        end
    endtask
    // wait for launch, then count half steps until the synced output rises
    task meas(input int p, input int h);
        int c;
        c = 0;
        while (busy !== 1'b0 && c < 1000) begin
            @(posedge clk);
            #1 c++;
        end
        if (c == 1000) begin
            chk("launch", 32'h0, 32'h1);
            conclude();
        end
        wait_out(p, 1'b1, c);
        chk("hold", 32'(c), 32'(h));
    endtask
    task sync_pin;
        @(posedge clk);
        sync_req <= 1'b1;
        @(posedge clk);
        sync_req <= 1'b0;
        #1 chk("busy", {31'h0, busy}, 32'h1);
    endtask
    task chk_rst;
        rreg(`DOD_CTRL_OFS, rv);
        chk("ctrl", rv, `DOD_CTRL_RST);
        rreg(`DOD_SYNC_EN_OFS, rv);
        chk("sync_en", rv, `DOD_SYNC_EN_RST);
        rreg(`DOD_STATUS_OFS, rv);
        chk("status", rv, 32'h0);
        rreg(8'h28, rv);
        chk("pair", rv, {7'h0, `DOD_PAIR_HS_RST, 2'h0, `DOD_PAIR_DLY_RST, 5'h0, `DOD_PAIR_DIV_RST});
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        sync_req = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        error_cnt = 0;
        checked = 0;
        rows = '{'{`DOD_SYNC_EN_OFS, 32'h7F, 32'h7F}, '{8'h14, 32'h0105_0014, 32'h0105_0014},
            '{`DOD_CTRL_OFS, 32'h201, 32'h201}, '{`DOD_CTRL_OFS, 32'h1, 32'h1},
            '{8'hFC, 32'hFFFF_FFFF, 32'h0}, '{8'h28, 32'h0009_0003, 32'h0009_0003}};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk_rst();
        foreach (rows[i]) begin
            wreg(rows[i].a, rows[i].d);
            rreg(rows[i].a, rv);
            chk("reg", rv, rows[i].e);
        end
        // pair 1 against qualifying pair 0; late write must not reach this sync
        wreg(`DOD_SYNC_EN_OFS, 32'h02);
        for (int k = 0; k < 5; k++) begin
            wreg(8'h14, {7'h0, hs[k], 2'h0, cnt[k], 5'h0, 11'd10});
            sync_pin();
            fork
                wreg(8'h14, 32'h0128_000A);
                meas(1, 2 * cnt[k] - hs[k]);
            join
            rreg(`DOD_STATUS_OFS, rv);
            chk("count", rv, 32'(k + 1) << 8);
        end
        // same pair qualifies and syncs: each event shifts it again
        wreg(`DOD_SYNC_EN_OFS, 32'h01);
        repeat (2) begin
            sync_pin();
            meas(0, 27);
        end
        wreg(`DOD_SYNC_EN_OFS, 32'h02);
        wreg(`DOD_SYNC_CMD_OFS, 32'h1);
        #1 chk("busy", {31'h0, busy}, 32'h1);
        meas(1, 79);
        // qualifying pair 2 is out of phase with pair 0 after the relative shifts
        wreg(`DOD_CTRL_OFS, 32'h201);
        sync_pin();
        meas(1, 79);
        // a sync with enable low is lost
        @(posedge clk);
        ce <= 1'b0;
        sync_req <= 1'b1;
        @(posedge clk);
        sync_req <= 1'b0;
        ce <= 1'b1;
        #1 chk("busy", {31'h0, busy}, 32'h0);
        // half step is one clock bypassed, two with post divide 2
        for (int k = 1; k < 3; k++) begin
            wreg(`DOD_CTRL_OFS, k == 1 ? 32'h1 : 32'h20);
            wait_out(2, 1'b0, n);
            wait_out(2, 1'b1, n);
            wait_out(2, 1'b0, n);
            chk("high", 32'(n), 32'(10 * k));
        end
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk_rst();
        conclude();
    end
endmodule

/* test/dod_top_chk.sv */
// assertions on the ports of the dynamic output delay top
// assumes bind into dod_top and dod_cfg.svh on the include path
`timescale 1ns/100ps
`include "dod_cfg.svh"
module dod_top_chk #(
    parameter int NPAIRS = 7,
    parameter int PDIV_W = 4,
    parameter int CNT_W = 8
) (
    input wire logic clk, // block clock
    input wire logic rst_n, // reset, active low
    input wire logic ce, // clock enable
    input wire logic sync_req, // sync pin
    input wire logic [7:0] addr, // byte address
    input wire logic [31:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    input wire logic [31:0] rdata, // read data
    input wire logic [NPAIRS-1:0] clk_out, // pair outputs
    input wire logic busy // sync pending
);
    // ----------------------------------------
    // shadows and properties
    // ----------------------------------------
    logic [NPAIRS-1:0] en_q;
    logic [2:0] qs_q;
    wire wr_go = wr && ce;
    wire cmd = ce && (sync_req || (wr && addr == `DOD_SYNC_CMD_OFS && wdata[0]));
    // mirror of sync enable and qualifying select, bench never writes them mid-sync
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= '0;
            qs_q <= 3'h0;
        end else if (wr_go && addr == `DOD_SYNC_EN_OFS) begin
            en_q <= wdata[NPAIRS-1:0];
        end else if (wr_go && addr == `DOD_CTRL_OFS) begin
            qs_q <= wdata[`DOD_CTRL_QSEL_MSB:`DOD_CTRL_QSEL_LSB];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_take; cmd && !busy; endsequence
    sequence s_launch; $fell(busy); endsequence
    property p_busy_up; s_take |=> busy; endproperty
    a_busy_up: assert property (p_busy_up) else $error("busy missing after sync");
    property p_busy_end; $rose(busy) |-> ##[1:1000] !busy; endproperty
    a_busy_end: assert property (p_busy_end) else $error("sync never launched");
    property p_no_spur; $rose(busy) |-> $past(cmd); endproperty
    a_no_spur: assert property (p_no_spur) else $error("busy without sync");
    property p_hold; s_launch |-> ((clk_out & en_q) == '0) [*8]; endproperty
    a_hold: assert property (p_hold) else $error("synced output not held off");
    property p_qual;
        s_launch ##0 (qs_q < NPAIRS) ##0 !en_q[qs_q] |-> $rose(clk_out[qs_q]);
    endproperty
    a_qual: assert property (p_qual) else $error("launch not on qualifying rise");
    property p_rd_idle; !$past(rd && ce) && $past(ce) |-> rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
    property p_unmap; $past(rd && ce && int'(addr) >= 16 + 4 * NPAIRS) |-> rdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_stat; $past(rd && ce && addr == `DOD_STATUS_OFS) |-> rdata[0] == $past(busy);
    endproperty
    a_stat: assert property (p_stat) else $error("status busy bit wrong");
    property p_freeze; !ce |=> $stable(clk_out) && $stable(busy); endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with enable low");
endmodule
bind dod_top dod_top_chk #(.NPAIRS(NPAIRS), .PDIV_W(PDIV_W), .CNT_W(CNT_W)) i_dod_top_chk (
    .clk(clk), .rst_n(rst_n), .ce(ce), .sync_req(sync_req), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .clk_out(clk_out), .busy(busy));
